// ### hdl/wtx_pkg.sv
// Package: timing constants and state type for the wireless transmitter drive control
package wtx_pkg;

  // ==========================================================================
  // Clock
  // ==========================================================================
  localparam longint unsigned WTX_CLK_HZ = 64'd200_000_000;

  // ==========================================================================
  // Times in their own units
  // ==========================================================================
  localparam longint unsigned WTX_DC_BUZZ_MS = 64'd500;   // 0.5 s
  localparam longint unsigned WTX_AC_BUZZ_MS = 64'd200;   // 0.2 s
  localparam longint unsigned WTX_AC_TONE_HZ = 64'd4000;
  localparam longint unsigned WTX_SUSPEND_S = 64'd300;    // About five minutes
  localparam longint unsigned WTX_STARTUP_NS = 64'd1000;  // Internal startup sequence length

  // ==========================================================================
  // Derived cycle counts
  // ==========================================================================
  localparam longint unsigned WTX_DC_BUZZ_CYC = WTX_CLK_HZ * WTX_DC_BUZZ_MS / 64'd1000;
  localparam longint unsigned WTX_AC_BUZZ_CYC = WTX_CLK_HZ * WTX_AC_BUZZ_MS / 64'd1000;
  localparam longint unsigned WTX_AC_HALF_CYC = WTX_CLK_HZ / (64'd2 * WTX_AC_TONE_HZ);
  localparam longint unsigned WTX_SUSPEND_CYC = WTX_CLK_HZ * WTX_SUSPEND_S;
  // Least time: round up
  localparam longint unsigned WTX_STARTUP_CYC_L =
    (WTX_STARTUP_NS * WTX_CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
  localparam logic [7:0] WTX_STARTUP_CYC = WTX_STARTUP_CYC_L[7:0];

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int WTX_HALF_W = 16;
  localparam int WTX_LONG_W = 36;
  localparam int WTX_BUZZ_W = 27;
  localparam logic WTX_PIN_HIGH = 1'b1;
  localparam logic WTX_PIN_LOW = 1'b0;

  typedef enum logic [1:0] {
    WTX_ST_RESET,
    WTX_ST_STARTUP,
    WTX_ST_RUN,
    WTX_ST_SUSPEND
  } wtx_state_type;

endpackage

// ### hdl/wtx_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module wtx_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================================
  // Stages
  // ==========================================================================
  // First stage feeds only the second, to contain metastability
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept only a level seen on two later stages
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_out <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end

endmodule

// ### hdl/wtx_drive_ctrl.sv
// Coil drive, buzzer, damping and supervision logic of the wireless power transmitter
//
// Contract
// - Coil drive is a 50% square wave whose frequency the feedback loop sets.
// - Topology select low: driver enable held high, square wave on coil drive only.
// - Topology select high: both outputs square; enable pulse shorter to give dead time.
// - Transfer start drives the DC buzzer high for 0.5 s.
// - Transfer start gives a 0.2 s 4000 Hz burst on the AC buzzer, idle otherwise.
// - Temperature comparator trip at 1.25 V stops transfer and enters suspend.
// - Suspend retries after about five minutes or when the receiver is removed.
// - Coil damping output follows the protocol's damping request.
// - Supply above release level starts a startup sequence, then normal operation.
// - Device stays in reset while the external reset pin is low.
`timescale 1ns/1ps
module wtx_drive_ctrl
  import wtx_pkg::*;
#(
  parameter logic [WTX_LONG_W-1:0] SUSPEND_CYCLES = WTX_SUSPEND_CYC[WTX_LONG_W-1:0],
  parameter logic [WTX_BUZZ_W-1:0] DC_BUZZ_CYCLES = WTX_DC_BUZZ_CYC[WTX_BUZZ_W-1:0],
  parameter logic [WTX_BUZZ_W-1:0] AC_BUZZ_CYCLES = WTX_AC_BUZZ_CYC[WTX_BUZZ_W-1:0],
  parameter logic [WTX_HALF_W-1:0] AC_HALF_CYCLES = WTX_AC_HALF_CYC[WTX_HALF_W-1:0]
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ext_reset_n,
  input wire logic supply_above_release,
  input wire logic drive_topology_select,
  input wire logic temp_over_threshold,
  input wire logic receiver_present,
  input wire logic transfer_start,
  input wire logic damping_request,
  input wire logic [WTX_HALF_W-1:0] half_period,
  input wire logic [WTX_HALF_W-1:0] dead_cycles,
  output logic coil_drive_out,
  output logic driver_enable_out,
  output logic coil_damping_out,
  output logic dc_buzzer_out,
  output logic ac_buzzer_out,
  output logic transfer_active,
  output logic suspended
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic rst_n_s;
  logic supply_s;
  logic topo_s;
  logic temp_s;

  wtx_pin_sync #(.RST_VAL(WTX_PIN_LOW)) u_sync_rst (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(ext_reset_n),
    .level_out(rst_n_s)
  );

  wtx_pin_sync #(.RST_VAL(WTX_PIN_LOW)) u_sync_supply (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(supply_above_release),
    .level_out(supply_s)
  );

  wtx_pin_sync #(.RST_VAL(WTX_PIN_LOW)) u_sync_topo (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(drive_topology_select),
    .level_out(topo_s)
  );

  // Trip held asserted at reset so nothing drives before the first real sample
  wtx_pin_sync #(.RST_VAL(WTX_PIN_HIGH)) u_sync_temp (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(temp_over_threshold),
    .level_out(temp_s)
  );

  // ==========================================================================
  // Supervisor state machine
  // ==========================================================================
  wtx_state_type state_q;
  wtx_state_type state_d;
  logic [7:0] start_cnt_q;
  logic [WTX_LONG_W-1:0] susp_cnt_q;
  logic hold_reset;
  logic run;
  logic start_done;
  logic susp_done;

  assign hold_reset = !rst_n_s || !supply_s;
  assign run = (state_q == WTX_ST_RUN);
  assign start_done = (start_cnt_q == WTX_STARTUP_CYC - 8'h01);
  assign susp_done = (susp_cnt_q == SUSPEND_CYCLES - 36'h0_0000_0001);

  // Next state; reset hold overrides every other condition
  always_comb begin
    state_d = state_q;
    if (hold_reset) begin
      state_d = WTX_ST_RESET;
    end else begin
      unique case (state_q)
        WTX_ST_RESET: begin
          state_d = WTX_ST_STARTUP;
        end
        WTX_ST_STARTUP: begin
          if (start_done) begin
            state_d = WTX_ST_RUN;
          end
        end
        WTX_ST_RUN: begin
          if (temp_s) begin
            state_d = WTX_ST_SUSPEND;
          end
        end
        WTX_ST_SUSPEND: begin
          // A retry with the trip still present drops straight back here
          if (susp_done || !receiver_present) begin
            state_d = WTX_ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= WTX_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Startup sequence length
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_cnt_q <= 8'h00;
    end else if (state_q == WTX_ST_STARTUP && !start_done) begin
      start_cnt_q <= start_cnt_q + 8'h01;
    end else begin
      start_cnt_q <= 8'h00;
    end
  end

  // Suspend retry timer, restarted on each entry
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      susp_cnt_q <= '0;
    end else if (state_q == WTX_ST_SUSPEND && !susp_done) begin
      susp_cnt_q <= susp_cnt_q + 36'h0_0000_0001;
    end else begin
      susp_cnt_q <= '0;
    end
  end

  // ==========================================================================
  // Variable frequency square wave
  // ==========================================================================
  logic [WTX_HALF_W-1:0] pwm_cnt_q;
  logic [WTX_HALF_W-1:0] half_q;
  logic [WTX_HALF_W-1:0] dead_q;
  logic phase_q;
  logic half_end;

  assign half_end = (pwm_cnt_q >= half_q - 16'h0001);

  // New period taken only at a half boundary so both halves stay equal
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_cnt_q <= '0;
      phase_q <= 1'b0;
      half_q <= 16'h0001;
      dead_q <= '0;
    end else if (!run) begin
      pwm_cnt_q <= '0;
      phase_q <= 1'b0;
      half_q <= (half_period == '0) ? 16'h0001 : half_period;
      dead_q <= dead_cycles;
    end else if (half_end) begin
      pwm_cnt_q <= '0;
      phase_q <= !phase_q;
      if (phase_q) begin
        half_q <= (half_period == '0) ? 16'h0001 : half_period;
        dead_q <= dead_cycles;
      end
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 16'h0001;
    end
  end

  // Registered pin drivers; enable pulse starts late by the dead count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coil_drive_out <= 1'b0;
      driver_enable_out <= 1'b0;
      coil_damping_out <= 1'b0;
    end else if (!run) begin
      coil_drive_out <= 1'b0;
      driver_enable_out <= 1'b0;
      coil_damping_out <= 1'b0;
    end else begin
      coil_drive_out <= phase_q;
      if (topo_s) begin
        driver_enable_out <= phase_q && (pwm_cnt_q >= dead_q);
      end else begin
        driver_enable_out <= 1'b1;
      end
      coil_damping_out <= damping_request;
    end
  end

  // ==========================================================================
  // Buzzers
  // ==========================================================================
  logic [WTX_BUZZ_W-1:0] dc_cnt_q;
  logic [WTX_BUZZ_W-1:0] ac_cnt_q;
  logic [WTX_HALF_W-1:0] tone_cnt_q;
  logic tone_q;
  logic start_take;

  assign start_take = run && transfer_start;

  // Burst timers; a repeat start restarts both
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dc_cnt_q <= '0;
      ac_cnt_q <= '0;
    end else if (!run) begin
      dc_cnt_q <= '0;
      ac_cnt_q <= '0;
    end else if (start_take) begin
      dc_cnt_q <= DC_BUZZ_CYCLES;
      ac_cnt_q <= AC_BUZZ_CYCLES;
    end else begin
      if (dc_cnt_q != '0) begin
        dc_cnt_q <= dc_cnt_q - 27'h000_0001;
      end
      if (ac_cnt_q != '0) begin
        ac_cnt_q <= ac_cnt_q - 27'h000_0001;
      end
    end
  end

  // Tone divider runs only inside the burst, so each burst opens with a high half
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tone_cnt_q <= '0;
      tone_q <= 1'b0;
    end else if (ac_cnt_q == '0 || start_take) begin
      tone_cnt_q <= '0;
      tone_q <= 1'b1;
    end else if (tone_cnt_q == AC_HALF_CYCLES - 16'h0001) begin
      tone_cnt_q <= '0;
      tone_q <= !tone_q;
    end else begin
      tone_cnt_q <= tone_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dc_buzzer_out <= 1'b0;
      ac_buzzer_out <= 1'b0;
    end else begin
      dc_buzzer_out <= run && (dc_cnt_q != '0);
      ac_buzzer_out <= run && (ac_cnt_q != '0) && tone_q;
    end
  end

  // Status flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      transfer_active <= 1'b0;
      suspended <= 1'b0;
    end else begin
      transfer_active <= run;
      suspended <= (state_q == WTX_ST_SUSPEND);
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_dc_high;
    dc_buzzer_out [*8];
  endsequence

  sequence s_half_wait;
    (run && !half_end) [*2];
  endsequence

  a_idle_outside_run: assert property (!run |=> !coil_drive_out && !driver_enable_out
      && !coil_damping_out && !dc_buzzer_out && !ac_buzzer_out)
    else $error("outputs active outside run");
  a_enable_held_buck: assert property (run && !topo_s |=> driver_enable_out)
    else $error("driver enable not held high");
  a_enable_inside_drive: assert property (run && topo_s |=> !driver_enable_out || coil_drive_out)
    else $error("enable pulse outside coil pulse");
  a_phase_half_len: assert property (run && $changed(phase_q) && $past(run) |-> $past(half_end))
    else $error("phase toggled before half end");
  a_phase_hold: assert property (s_half_wait |-> $stable(phase_q))
    else $error("phase moved mid half");
  a_dc_burst_start: assert property (start_take ##1 run |=> s_dc_high)
    else $error("dc buzzer burst too short");
  a_ac_idle_burst: assert property (ac_buzzer_out |-> $past(ac_cnt_q) != '0)
    else $error("ac buzzer active outside burst");
  a_trip_suspend: assert property (run && temp_s && !hold_reset |=> state_q == WTX_ST_SUSPEND)
    else $error("trip did not suspend");
  a_retry_resume: assert property (state_q == WTX_ST_SUSPEND && (susp_done || !receiver_present)
      && !hold_reset |=> run)
    else $error("suspend did not retry");
  a_damp_follow: assert property (run && damping_request |=> coil_damping_out)
    else $error("damping not applied");
  a_startup_wait: assert property (state_q == WTX_ST_STARTUP && !start_done |=> !run)
    else $error("run before startup end");
  a_reset_hold: assert property (!rst_n_s |=> state_q == WTX_ST_RESET ##1 !transfer_active)
    else $error("not held in reset");

endmodule

// ### testbench/wtx_power_train_model.sv
// Gate driver and power train model: measures drive pulses, returns the thermal comparator level
`timescale 1ns/1ps
module wtx_power_train_model (
  input wire logic clk,
  input wire logic coil_drive_out,
  input wire logic driver_enable_out,
  input wire logic heat,
  output logic temp_over_threshold,
  output int hi_len,
  output int lo_len,
  output int en_len,
  output int en_bad
);
  int c_cnt;
  int e_cnt;
  logic c_q;
  logic e_q;
  initial begin
    {c_cnt, e_cnt, hi_len, lo_len, en_len, en_bad} = '0;
    {c_q, e_q} = 2'b00;
  end
  // ==========================================================================
  // Thermal divider
  // ==========================================================================
  // Comparator output only; the divider itself is analogue and not modelled
  assign temp_over_threshold = heat;
  // ==========================================================================
  // Pulse measurement
  // ==========================================================================
  // Lengths are taken at each edge, so a changed period shows after one full wave
  always @(posedge clk) begin
    c_q <= coil_drive_out;
    e_q <= driver_enable_out;
    c_cnt <= (coil_drive_out == c_q) ? c_cnt + 1 : 1;
    if (coil_drive_out != c_q && !coil_drive_out) hi_len <= c_cnt;
    if (coil_drive_out != c_q && coil_drive_out) lo_len <= c_cnt;
    e_cnt <= driver_enable_out ? e_cnt + 1 : 0;
    if (e_q && !driver_enable_out) en_len <= e_cnt;
    // Enable while the coil output is low would short the bridge
    if (driver_enable_out && !coil_drive_out) en_bad <= en_bad + 1;
  end
endmodule

// ### testbench/tb.sv
// Self-checking bench for the wireless transmitter drive control
`timescale 1ns/1ps
module tb;
  import wtx_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_reset_n = 1'b0;
  logic supply_above_release = 1'b0;
  logic drive_topology_select = 1'b0;
  logic heat = 1'b0;
  logic temp_over_threshold;
  logic receiver_present = 1'b1;
  logic transfer_start = 1'b0;
  logic damping_request = 1'b0;
  logic [WTX_HALF_W-1:0] half_period = 16'h0008;
  logic [WTX_HALF_W-1:0] dead_cycles = 16'h0002;
  logic coil_drive_out, driver_enable_out, coil_damping_out, dc_buzzer_out, ac_buzzer_out;
  logic transfer_active, suspended;
  int hi_len, lo_len, en_len, en_bad;
  int n_mismatch = 0;
  int tests_run = 0;
  wire logic any_out = coil_drive_out | driver_enable_out | coil_damping_out | dc_buzzer_out | ac_buzzer_out;
  // ==========================================================================
  // Clock and instances
  // ==========================================================================
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Short counts keep the run small; expectations follow these values
  wtx_drive_ctrl #(.SUSPEND_CYCLES(36'd100), .DC_BUZZ_CYCLES(27'd40), .AC_BUZZ_CYCLES(27'd30),
    .AC_HALF_CYCLES(16'd3)) i_wtx_drive_ctrl (.clk(clk), .sys_rst(sys_rst), .ext_reset_n(ext_reset_n),
    .supply_above_release(supply_above_release), .drive_topology_select(drive_topology_select),
    .temp_over_threshold(temp_over_threshold), .receiver_present(receiver_present),
    .transfer_start(transfer_start), .damping_request(damping_request), .half_period(half_period),
    .dead_cycles(dead_cycles), .coil_drive_out(coil_drive_out), .driver_enable_out(driver_enable_out),
    .coil_damping_out(coil_damping_out), .dc_buzzer_out(dc_buzzer_out), .ac_buzzer_out(ac_buzzer_out),
    .transfer_active(transfer_active), .suspended(suspended));
  wtx_power_train_model i_wtx_power_train_model (.clk(clk), .coil_drive_out(coil_drive_out),
    .driver_enable_out(driver_enable_out), .heat(heat), .temp_over_threshold(temp_over_threshold),
    .hi_len(hi_len), .lo_len(lo_len), .en_len(en_len), .en_bad(en_bad));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %b", $time, msg, got);
      n_mismatch++;
    end
  endtask
  task automatic chk_num(input int got, input int exp, input string msg);
    tests_run++;
    if (got != exp) begin
      $display("wrong value at %0t: %s got %0d expected %0d", $time, msg, got, exp);
      n_mismatch++;
    end
  endtask
  // Bounded wait on transfer_active (sel 0) or suspended (sel 1)
  task automatic wait_sig(input int sel, input logic val, input int lim, output int n);
    n = 0;
    while (((sel == 0) ? transfer_active : suspended) !== val) begin
      tick(1);
      n++;
      if (n > lim) begin
        $display("wrong value at %0t: wait ran out", $time);
        n_mismatch++;
        results();
      end
    end
  endtask
  // Sample outputs for a while; any active drive is remembered
  task automatic quiet(input int n, output logic acc);
    acc = 1'b0;
    repeat (n) begin
      tick(1);
      acc = acc | any_out;
    end
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_startup();
    int n;
    logic acc;
    @(posedge clk) ext_reset_n <= 1'b1;
    quiet(50, acc);
    chk_bit(acc | transfer_active, 1'b0, "active with supply low");
    @(posedge clk) supply_above_release <= 1'b1;
    wait_sig(0, 1'b1, 260, n);
    chk_bit(n >= 200 && n <= 215, 1'b1, "startup length");
  endtask
  task automatic t_wave(input logic sel, input int half, output logic en_all);
    @(posedge clk) drive_topology_select <= sel;
    half_period <= half[WTX_HALF_W-1:0];
    tick(70);
    en_all = 1'b1;
    repeat (30) begin
      tick(1);
      en_all = en_all & driver_enable_out;
    end
    chk_num(hi_len, half, "high half");
    chk_num(lo_len, half, "low half");
  endtask
  task automatic t_topology();
    logic en_all;
    int b;
    t_wave(1'b0, 8, en_all);
    chk_bit(en_all, 1'b1, "enable held");
    t_wave(1'b1, 5, en_all);
    b = en_bad;
    tick(40);
    chk_num(en_len, 3, "enable pulse");
    chk_num(en_bad - b, 0, "enable outside coil high");
  endtask
  task automatic t_buzz();
    int dc, ac, rises;
    logic prev;
    @(posedge clk) transfer_start <= 1'b1;
    @(posedge clk) transfer_start <= 1'b0;
    // Outputs rise one edge after the pulse is taken; look at that very cycle
    tick(1);
    chk_bit(dc_buzzer_out & ac_buzzer_out, 1'b1, "buzzers start");
    {dc, ac, rises} = '0;
    prev = 1'b1;
    dc = 1;
    ac = 1;
    repeat (80) begin
      tick(1);
      dc += dc_buzzer_out;
      ac += ac_buzzer_out;
      rises += (ac_buzzer_out & !prev);
      prev = ac_buzzer_out;
    end
    chk_num(dc, 40, "dc buzzer length");
    chk_num(ac, 15, "ac high cycles");
    chk_num(rises, 4, "ac rises after first");
  endtask
  task automatic t_damp();
    @(posedge clk) damping_request <= 1'b1;
    tick(3);
    chk_bit(coil_damping_out, 1'b1, "damping on");
    @(posedge clk) damping_request <= 1'b0;
    tick(3);
    chk_bit(coil_damping_out, 1'b0, "damping off");
  endtask
  task automatic t_temp();
    int n;
    logic acc;
    @(posedge clk) heat <= 1'b1;
    damping_request <= 1'b1;
    wait_sig(1, 1'b1, 20, n);
    @(posedge clk) heat <= 1'b0;
    quiet(10, acc);
    chk_bit(acc, 1'b0, "drive in suspend");
    wait_sig(0, 1'b1, 130, n);
    chk_bit(n >= 85, 1'b1, "early retry");
    @(posedge clk) heat <= 1'b1;
    wait_sig(1, 1'b1, 20, n);
    @(posedge clk) heat <= 1'b0;
    // Let the trip clear through the synchroniser first, else the retry suspends again
    tick(6);
    @(posedge clk) receiver_present <= 1'b0;
    wait_sig(0, 1'b1, 8, n);
    @(posedge clk) receiver_present <= 1'b1;
    damping_request <= 1'b0;
  endtask
  task automatic t_extrst();
    int n;
    logic acc;
    @(posedge clk) ext_reset_n <= 1'b0;
    wait_sig(0, 1'b0, 10, n);
    quiet(30, acc);
    chk_bit(acc | transfer_active, 1'b0, "outputs in reset");
    @(posedge clk) ext_reset_n <= 1'b1;
    wait_sig(0, 1'b1, 260, n);
    chk_bit(n >= 200, 1'b1, "restart length");
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
    chk_bit(any_out, 1'b0, "outputs after reset");
    t_startup();
    t_topology();
    t_buzz();
    t_damp();
    t_temp();
    t_extrst();
    results();
  end
endmodule
